// File: verif/compare_timer_properties.sv
// Port assertions for the compare timer
`timescale 1ns/10ps
module compare_timer_checker (
	input wire core_clk,
	input wire rst_n,
	input wire [9:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire [9:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire pulse_output,
	input wire timer_interrupt
);
	reg [9:0] rd_addr;
	wire both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire reset_write = both && s_axi_awaddr == 10'h050 && s_axi_wdata[7];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	always @(posedge core_clk)
		if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
	a_irq_single: assert property (
		timer_interrupt |=> !timer_interrupt) else $error("wide interrupt");
	a_reset_clears_out: assert property (
		reset_write |-> ##[1:4] !pulse_output) else $error("output not cleared");
	a_reset_reads_zero: assert property (
		s_axi_rvalid && rd_addr == 10'h050 |-> !s_axi_rdata[7]) else $error("bit7");
	a_compare_unread: assert property (
		s_axi_rvalid && rd_addr[9:3] == 7'h0B |-> s_axi_rdata == 0) else $error("cmp");
	a_unmapped_err: assert property (s_axi_rvalid &&
		(rd_addr < 10'h050 || rd_addr > 10'h060) |-> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
	a_write_answer: assert property (
		both |-> ##[1:3] s_axi_bvalid) else $error("no bvalid");
endmodule // compare_timer_checker
bind compare_timer_control compare_timer_checker compare_timer_checker_i (
	.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .pulse_output, .timer_interrupt);

// File: verif/testbench.sv
// Self-checking bench of the compare timer
`timescale 1ns/10ps
`include "compare_timer_regs.vh"
module testbench;
	logic core_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, got, p;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, divider_option = 0;
	logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rdv, seed = 32'h0001_57FC;
	logic [3:0] s_axi_wstrb = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, trigger_pin, pulse_output, timer_interrupt;
	wire [31:0] s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] rsp;
	integer bad_count = 0, cmp_count = 0, n, t, a, b, c, i;
	compare_timer_control compare_timer_control_i (.core_clk, .rst_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .trigger_pin, .divider_option, .pulse_output,
		.timer_interrupt);
	trigger_source trigger_source_i (.core_clk, .trigger_pin);
	initial forever #2.5 core_clk = ~core_clk;
	function automatic [31:0] rnd;
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task complete_run;
		if (bad_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Kind 1 write, 0 read, 2 wait for interrupt while counting output flips
	task xfer(input [1:0] w, input [9:0] ad, input [31:0] d, input [3:0] s);
		@(posedge core_clk);
		s_axi_awaddr <= ad;
		s_axi_araddr <= ad;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= w == 1;
		s_axi_wvalid <= w == 1;
		s_axi_bready <= w == 1;
		s_axi_arvalid <= w == 0;
		s_axi_rready <= w == 0;
		got = 0;
		t = 0;
		p = pulse_output;
		for (n = 0; !got && n < 400; n = n + 1) begin
			@(posedge core_clk);
			t = t + (pulse_output !== p);
			p = pulse_output;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arready) s_axi_arvalid <= 0;
			got = w == 2 ? timer_interrupt : w == 1 ? s_axi_bvalid : s_axi_rvalid;
		end
		rdv = s_axi_rdata;
		rsp = w == 1 ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		chk(got, 1);
		if (!got) complete_run;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1;
		xfer(0, `ADDR_CONTROL_LOW, 0, 0);
		chk(rdv, 0);
		xfer(0, 10'h3FC, 0, 0);
		a = 4 + rnd() % 6;
		divider_option <= seed[3];
		b = a + 2 + rnd() % 4;
		c = b + 2 + rnd() % 4;
		xfer(1, `ADDR_CONTROL_HIGH, 32'h0000_000A, 4'hF);
		xfer(1, `ADDR_COMPARE, 32'h0000_0030, 4'h3);
		chk(rsp, `RESP_OKAY);
		xfer(1, `ADDR_COMPARE, a, 4'h3);
		xfer(1, `ADDR_CONTROL_LOW, 32'h0000_0001, 4'hF);
		xfer(2, 0, 0, 0);
		xfer(0, `ADDR_STATUS, 0, 0);
		chk(rdv[15:0] <= a && rdv[16], 1);
		chk(rdv[18:17], 0);
		xfer(1, `ADDR_CONTROL_LOW, 0, 4'hF);
		xfer(0, `ADDR_STATUS, 0, 0);
		chk(rdv[16:0], 0);
		xfer(1, `ADDR_CONTROL_LOW, 32'h0000_0011, 4'hF);
		xfer(2, 0, 0, 0);
		xfer(0, `ADDR_CONTROL_LOW, 0, 0);
		chk(rdv, 32'h0000_0010);
		xfer(0, `ADDR_COMPARE, 0, 0);
		chk(rdv, 0);
		chk(rsp, `RESP_OKAY);
		xfer(1, `ADDR_CONTROL_HIGH, 32'h0000_002B, 4'hF);
		xfer(1, `ADDR_CONTROL_LOW, 32'h0000_0020, 4'hF);
		xfer(1, `ADDR_COMPARE, a, 4'h1);
		xfer(1, `ADDR_COMPARE_HIGH, 0, 4'h1);
		xfer(0, `ADDR_STATUS, 0, 0);
		chk(rdv[18:17], 1);
		chk(rdv[19], 1);
		xfer(1, `ADDR_COMPARE, b, 4'h3);
		xfer(1, `ADDR_COMPARE, c, 4'h3);
		xfer(1, `ADDR_CONTROL_LOW, 32'h0000_0021, 4'hF);
		@(posedge core_clk);
		chk(pulse_output, 1);
		xfer(2, 0, 0, 0);
		chk(t, 3);
		xfer(1, `ADDR_CONTROL_LOW, 32'h0000_0080, 4'hF);
		chk(pulse_output, 0);
		for (i = 0; i < 2; i = i + 1) begin
			xfer(1, `ADDR_CONTROL_HIGH, 32'h0000_000E | i << 6, 4'hF);
			xfer(1, `ADDR_CONTROL_LOW, 32'h0000_0001, 4'hF);
			trigger_source_i.pulses(3);
			xfer(0, `ADDR_STATUS, 0, 0);
			chk(rdv[15:0], i ? 0 : 3);
			xfer(1, `ADDR_CONTROL_LOW, 0, 4'hF);
		end
		complete_run;
	end
endmodule // testbench

// File: verif/trigger_source.sv
// Behavioural source of the trigger and count pin
`timescale 1ns/10ps
module trigger_source (
	input wire core_clk,
	output logic trigger_pin = 1'b0
);
	task pulses(input integer k);
		repeat (k) begin
			repeat (4) @(posedge core_clk);
			trigger_pin <= 1'b1;
			repeat (4) @(posedge core_clk);
			trigger_pin <= 1'b0;
		end
		repeat (8) @(posedge core_clk);
	endtask
endmodule // trigger_source

// File: verilog/compare_timer_control.v
// Compare timer/counter with AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "compare_timer_regs.vh"
module compare_timer_control (
	input wire core_clk,
	input wire rst_n,
	input wire [9:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [9:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire trigger_pin,
	input wire divider_option,
	output reg pulse_output,
	output reg timer_interrupt
);
	reg [7:0] timer_control_low;
	reg [6:0] timer_control_high;
	reg [15:0] compare_value_a;
	reg [15:0] compare_value_b;
	reg [15:0] compare_value_c;
	reg [1:0] load_index;
	reg [7:0] low_byte_hold;
	reg [15:0] counter;
	reg [`PRESCALE_WIDTH-1:0] prescale;
	reg output_flop;
	reg running;
	reg pin_meta;
	reg pin_sync;
	reg pin_last;
	reg [9:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;
	wire start_control = timer_control_low[`LOW_START_CONTROL];
	wire start_source = timer_control_low[`LOW_START_SOURCE];
	wire both_edges_enable = timer_control_low[`LOW_BOTH_EDGES];
	wire edge_polarity = timer_control_low[`LOW_EDGE_POLARITY];
	wire cycle_select = timer_control_low[`LOW_CYCLE_SELECT];
	wire operation_mode_select = timer_control_low[`LOW_MODE_SELECT];
	wire pulse_direction = timer_control_low[`LOW_PULSE_DIRECTION];
	wire [2:0] count_source_select =
		timer_control_high[`HIGH_CLOCK_LSB+2:`HIGH_CLOCK_LSB];
	wire [1:0] register_count =
		timer_control_high[`HIGH_REGCOUNT_LSB+1:`HIGH_REGCOUNT_LSB];
	wire trigger_disable = timer_control_high[`HIGH_TRIGGER_DISABLE];
	// Trigger input forced low when disabled
	wire trig_now = pin_sync & ~trigger_disable;
	wire trig_prev = pin_last & ~trigger_disable;
	wire rise = trig_now & ~trig_prev;
	wire fall = ~trig_now & trig_prev;
	wire active_edge = edge_polarity ? fall : rise;
	wire opposite_edge = edge_polarity ? rise : fall;
	// Both-edge stop only with trigger start
	wire stop_edge = start_source & both_edges_enable & opposite_edge;
	wire event_mode = (count_source_select == `COUNT_SOURCE_PIN) &
		~operation_mode_select;
	// Divided clock tap, one extra halving with divider option
	reg [3:0] tap;
	always @* begin
		case (count_source_select)
			3'h0: tap = 4'ha;
			3'h1: tap = 4'h6;
			3'h2: tap = 4'h4;
			3'h3: tap = 4'h2;
			3'h4: tap = 4'h1;
			default: tap = 4'h0;
		endcase
	end
	wire [3:0] tap_sel = tap + {3'h0, divider_option};
	wire [`PRESCALE_WIDTH-1:0] next_prescale = prescale + 1'b1;
	wire div_tick = ~prescale[tap_sel] & next_prescale[tap_sel];
	reg count_tick;
	always @* begin
		if (count_source_select == `COUNT_SOURCE_PIN)
			count_tick = active_edge;
		else if (count_source_select == `COUNT_SOURCE_UNUSED)
			count_tick = 1'b0;
		else
			count_tick = div_tick;
	end
	// Highest compare in use and match detection
	wire [1:0] eff_count = operation_mode_select ?
		((register_count == 2'h3) ? `REGCOUNT_A : register_count) :
		`REGCOUNT_A;
	wire [15:0] top_value = (eff_count == `REGCOUNT_ABC) ? compare_value_c :
		(eff_count == `REGCOUNT_AB) ? compare_value_b : compare_value_a;
	wire match_a = counter == compare_value_a;
	wire match_b = (eff_count != `REGCOUNT_A) & (counter == compare_value_b);
	wire match_c = (eff_count == `REGCOUNT_ABC) &
		(counter == compare_value_c);
	wire match_top = counter == top_value;
	wire flip = operation_mode_select & (match_a | match_b | match_c);
	// AXI write decode
	wire wr_go = aw_held & w_held & ~s_axi_bvalid;
	wire [9:0] wr_addr = aw_addr;
	wire wr_low = wr_go & (wr_addr == `ADDR_CONTROL_LOW) & w_strb[0];
	wire wr_high = wr_go & (wr_addr == `ADDR_CONTROL_HIGH) & w_strb[0];
	wire wr_cmp = wr_go & (wr_addr == `ADDR_COMPARE);
	wire wr_cmp_hi = wr_go & (wr_addr == `ADDR_COMPARE_HIGH) & w_strb[0];
	wire wr_mapped = (wr_addr == `ADDR_CONTROL_LOW) |
		(wr_addr == `ADDR_CONTROL_HIGH) | (wr_addr == `ADDR_COMPARE) |
		(wr_addr == `ADDR_COMPARE_HIGH) | (wr_addr == `ADDR_STATUS);
	wire cmp_word = wr_cmp & (&w_strb[1:0]);
	wire cmp_lowb = wr_cmp & w_strb[0] & ~w_strb[1];
	// Word write, or low byte then high byte completes a value
	wire cmp_load = cmp_word | wr_cmp_hi;
	wire [15:0] cmp_value = cmp_word ? w_data[15:0] :
		{w_data[7:0], low_byte_hold};
	wire reset_all = wr_low & w_data[`LOW_RESET_ALL];
	wire [7:0] next_low = {1'b0, w_data[6:0]};
	always @(posedge core_clk) begin
		if (!rst_n) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_last <= 1'b0;
		end else begin
			pin_meta <= trigger_pin;
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end
	// Registers and counter
	always @(posedge core_clk) begin
		if (!rst_n) begin
			timer_control_low <= `CONTROL_LOW_RESET;
			timer_control_high <= `CONTROL_HIGH_RESET;
			compare_value_a <= `COMPARE_RESET;
			compare_value_b <= `COMPARE_RESET;
			compare_value_c <= `COMPARE_RESET;
			load_index <= 2'h0;
			low_byte_hold <= 8'h00;
			counter <= 16'h0000;
			prescale <= {`PRESCALE_WIDTH{1'b0}};
			output_flop <= 1'b0;
			running <= 1'b0;
			pulse_output <= 1'b0;
			timer_interrupt <= 1'b0;
		end else if (reset_all) begin
			// Pulse already launched is cut short, output driven low
			timer_interrupt <= 1'b0;
			timer_control_low <= `CONTROL_LOW_RESET;
			timer_control_high <= `CONTROL_HIGH_RESET;
			load_index <= 2'h0;
			counter <= 16'h0000;
			prescale <= {`PRESCALE_WIDTH{1'b0}};
			output_flop <= 1'b0;
			running <= 1'b0;
			pulse_output <= 1'b0;
		end else begin
			timer_interrupt <= 1'b0;
			prescale <= next_prescale;
			if (wr_low)
				timer_control_low <= next_low;
			if (wr_high)
				timer_control_high <= w_data[6:0];
			if (wr_high)
				output_flop <= w_data[`HIGH_FLOP_INIT];
			if (cmp_lowb)
				low_byte_hold <= w_data[7:0];
			// Sequenced loads A, B, C; B/C gated by mode and count
			if (cmp_load) begin
				case (load_index)
					2'h0: begin
						compare_value_a <= cmp_value;
						load_index <= (eff_count == `REGCOUNT_A) ?
							2'h0 : 2'h1;
					end
					2'h1: begin
						if (eff_count != `REGCOUNT_A)
							compare_value_b <= cmp_value;
						load_index <= (eff_count == `REGCOUNT_ABC) ?
							2'h2 : 2'h0;
					end
					2'h2: begin
						if (eff_count == `REGCOUNT_ABC)
							compare_value_c <= cmp_value;
						load_index <= 2'h0;
					end
					default: load_index <= 2'h0;
				endcase
			end
			if (!start_control) begin
				// Stopped and cleared
				counter <= 16'h0000;
				running <= 1'b0;
			end else if (!running) begin
				// Software start, or trigger edge start
				if (!start_source || active_edge) begin
					running <= 1'b1;
					counter <= 16'h0000;
					// Pulse starting level
					if (operation_mode_select)
						pulse_output <= output_flop ^ pulse_direction;
				end
			end else if (stop_edge) begin
				counter <= 16'h0000;
				running <= 1'b0;
			end else if (count_tick) begin
				// Up-counter advanced by selected source
				counter <= counter + 16'h0001;
				if (flip) begin
					output_flop <= ~output_flop;
					pulse_output <= ~output_flop ^ pulse_direction;
				end
				if (match_top) begin
					// Interrupt and clear
					timer_interrupt <= 1'b1;
					counter <= 16'h0000;
					// One-shot stops after top match, except when counting pin events with mode select low
					if (cycle_select && !event_mode) begin
						running <= 1'b0;
						if (!start_source)
							timer_control_low[1:0] <= 2'h0;
					end
				end
			end
		end
	end
	// AXI4-Lite handshake
	always @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 10'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[9:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case ({s_axi_araddr[9:2], 2'h0})
					`ADDR_CONTROL_LOW:
						s_axi_rdata <= {24'h00_0000, timer_control_low};
					`ADDR_CONTROL_HIGH:
						s_axi_rdata <= {25'h000_0000, timer_control_high};
					`ADDR_COMPARE, `ADDR_COMPARE_HIGH:
						s_axi_rdata <= 32'h0000_0000;
					`ADDR_STATUS:
						s_axi_rdata <= {12'h000, output_flop, load_index,
							running, counter};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // compare_timer_control

// File: verilog/compare_timer_regs.vh
// Register offsets, fields and reset values of the compare timer
`ifndef COMPARE_TIMER_REGS_VH
`define COMPARE_TIMER_REGS_VH
`define IDX_CONTROL_LOW 8'h14
`define IDX_CONTROL_HIGH 8'h15
`define IDX_COMPARE 8'h16
`define IDX_COMPARE_HIGH 8'h17
`define IDX_STATUS 8'h18
`define ADDR_CONTROL_LOW 10'h050
`define ADDR_CONTROL_HIGH 10'h054
`define ADDR_COMPARE 10'h058
`define ADDR_COMPARE_HIGH 10'h05C
`define ADDR_STATUS 10'h060
`define LOW_START_CONTROL 0
`define LOW_START_SOURCE 1
`define LOW_BOTH_EDGES 2
`define LOW_EDGE_POLARITY 3
`define LOW_CYCLE_SELECT 4
`define LOW_MODE_SELECT 5
`define LOW_PULSE_DIRECTION 6
`define LOW_RESET_ALL 7
`define HIGH_FLOP_INIT 0
`define HIGH_CLOCK_LSB 1
`define HIGH_REGCOUNT_LSB 4
`define HIGH_TRIGGER_DISABLE 6
`define CONTROL_LOW_RESET 8'h00
`define CONTROL_HIGH_RESET 7'h00
`define COMPARE_RESET 16'h0000
`define COUNT_SOURCE_PIN 3'h7
`define COUNT_SOURCE_UNUSED 3'h6
`define REGCOUNT_A 2'h0
`define REGCOUNT_AB 2'h1
`define REGCOUNT_ABC 2'h2
`define PRESCALE_WIDTH 13
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif
